// [hw/ilmst_defines.svh]
`ifndef ILMST_DEFINES_SVH
`define ILMST_DEFINES_SVH

// ----------------------------------------------------------------------------
// Counter moduli and marker
// ----------------------------------------------------------------------------
`define ILMST_MOD_A       5'h1B
`define ILMST_MOD_B       5'h1C
`define ILMST_MARKER      5'h00
`define ILMST_CNT_RESET   5'h00

// ----------------------------------------------------------------------------
// Revolution counts
// ----------------------------------------------------------------------------
// The coincidence period is the product of the two coprime moduli.
`define ILMST_COIN_PERIOD 11'h2F4
`define ILMST_STOP_MIN    11'h2F4
`define ILMST_STOP_MAX    11'h5E8
`define ILMST_REV_SAT     11'h7FF

`endif

// [hw/ilmst_pkg.sv]
package ilmst_pkg;

   typedef logic [4:0]  ilmst_cnt_t;
   typedef logic [10:0] ilmst_rev_t;

   typedef enum logic [1:0]
   {
      ILMST_HELD    = 2'h0,
      ILMST_ARMED   = 2'h1,
      ILMST_STOPPED = 2'h3
   } ilmst_state_t;

endpackage

// [hw/ilmst_mod_ctr.sv]
`timescale 1ns/1ps
`include "ilmst_defines.svh"

module ilmst_mod_ctr
#(
   parameter ilmst_pkg::ilmst_cnt_t MODULUS = `ILMST_MOD_A
)
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  step,
   output ilmst_pkg::ilmst_cnt_t      count,
   output logic                       at_marker
);
   import ilmst_pkg::*;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= `ILMST_CNT_RESET;
      end
      else if (step)
      begin
         if (count == MODULUS - 5'h01)
         begin
            count <= `ILMST_CNT_RESET;
         end
         else
         begin
            count <= count + 5'h01;
         end
      end
   end

   assign at_marker = (count == `ILMST_MARKER);

endmodule

// [hw/ilmst_timer.sv]
`timescale 1ns/1ps
`include "ilmst_defines.svh"

module ilmst_timer
(
   input  wire logic REF_CLK,
   input  wire logic RESET_N,
   input  wire logic SHAFT_REV,
   input  wire logic LINE_SIG,
   input  wire logic TIMER_DISABLE,
   output logic      MOTOR_STOP,
   output logic      STOP_ARMED
);
   import ilmst_pkg::*;

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   logic [2:0]     pin_in;
   logic [2:0]     sync_a;
   logic [2:0]     sync_b;
   logic [2:0]     sync_c;
   logic           rev_evt;
   logic           line_evt;
   logic           disabled;
   logic           step;
   ilmst_cnt_t     cnt [2];
   logic [1:0]     marker;
   logic           coincident;
   logic           coin_q;
   logic           coin_evt;
   ilmst_state_t   state;
   ilmst_state_t   next_state;
   ilmst_rev_t     revs_since_coin;
   ilmst_rev_t     revs_since_line;

   assign pin_in = {TIMER_DISABLE, LINE_SIG, SHAFT_REV};

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sync
         always_ff @(posedge REF_CLK or negedge RESET_N)
         begin
            if (!RESET_N)
            begin
               sync_a[g] <= 1'b0;
               sync_b[g] <= 1'b0;
               sync_c[g] <= 1'b0;
            end
            else
            begin
               sync_a[g] <= pin_in[g];
               sync_b[g] <= sync_a[g];
               sync_c[g] <= sync_b[g];
            end
         end
      end
   endgenerate

   assign rev_evt  = sync_b[0] & ~sync_c[0];
   assign line_evt = sync_b[1] & ~sync_c[1];
   assign disabled = sync_b[2];
   // Gating the step rather than the latch keeps the counters parked, as a
   // disengaged pawl would, instead of merely hiding the pulse.
   assign step     = rev_evt & ~disabled;

   // -------------------------------------------------------------------------
   // Modulo counters
   // -------------------------------------------------------------------------
   generate
      for (g = 0; g < 2; g++)
      begin : g_ctr
         ilmst_mod_ctr
         #(
            .MODULUS ((g == 0) ? `ILMST_MOD_A : `ILMST_MOD_B)
         )
         u_ctr
         (
            .clk       (REF_CLK),
            .reset_n   (RESET_N),
            .step      (step),
            .count     (cnt[g]),
            .at_marker (marker[g])
         );
      end
   endgenerate

   // The markers stay aligned until the next step, a whole revolution.
   assign coincident = &marker;

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         coin_q <= 1'b1;
      end
      else
      begin
         coin_q <= coincident;
      end
   end

   assign coin_evt = coincident & ~coin_q;

   // -------------------------------------------------------------------------
   // Hold latch
   // -------------------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      unique case (state)
         ILMST_HELD:
         begin
            if (coin_evt && !line_evt)
            begin
               next_state = ILMST_ARMED;
            end
         end
         ILMST_ARMED:
         begin
            if (line_evt)
            begin
               next_state = ILMST_HELD;
            end
            else if (coin_evt)
            begin
               next_state = ILMST_STOPPED;
            end
         end
         ILMST_STOPPED:
         begin
            // The motor control brings the motor back; line activity then
            // starts a fresh measurement.
            if (line_evt)
            begin
               next_state = ILMST_HELD;
            end
         end
         default:
         begin
            next_state = ILMST_HELD;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state <= ILMST_HELD;
      end
      else
      begin
         state <= next_state;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         MOTOR_STOP <= 1'b0;
         STOP_ARMED <= 1'b0;
      end
      else
      begin
         MOTOR_STOP <= (state == ILMST_ARMED) && coin_evt && !line_evt;
         STOP_ARMED <= (next_state == ILMST_ARMED);
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         revs_since_coin <= 11'h000;
         revs_since_line <= 11'h000;
      end
      else
      begin
         if (coin_evt)
         begin
            revs_since_coin <= 11'h000;
         end
         else if (step)
         begin
            revs_since_coin <= revs_since_coin + 11'h001;
         end
         if (line_evt)
         begin
            revs_since_line <= 11'h000;
         end
         else if (step && revs_since_line != `ILMST_REV_SAT)
         begin
            revs_since_line <= revs_since_line + 11'h001;
         end
      end
   end

   property p_wrap_b;
      @(posedge REF_CLK) disable iff (!RESET_N)
      step && cnt[1] == 5'h1B |=> cnt[1] == 5'h00;
   endproperty
   a_wrap_b: assert property (p_wrap_b) else $error("Counter B failed to wrap.");

   property p_step_a;
      @(posedge REF_CLK) disable iff (!RESET_N)
      step && cnt[0] != 5'h1A |=> cnt[0] == $past(cnt[0]) + 5'h01;
   endproperty
   a_step_a: assert property (p_step_a) else $error("Counter A missed a step.");

   property p_arm;
      @(posedge REF_CLK) disable iff (!RESET_N)
      state == ILMST_HELD && coin_evt && !line_evt |=> state == ILMST_ARMED ##0 STOP_ARMED;
   endproperty
   a_arm: assert property (p_arm) else $error("Coincidence did not arm.");

   property p_period;
      @(posedge REF_CLK) disable iff (!RESET_N)
      revs_since_coin <= `ILMST_COIN_PERIOD;
   endproperty
   a_period: assert property (p_period) else $error("Coincidence period exceeded.");

   property p_persist;
      @(posedge REF_CLK) disable iff (!RESET_N)
      coincident && !step |=> coincident;
   endproperty
   a_persist: assert property (p_persist) else $error("Coincidence dropped early.");

   property p_relatch;
      @(posedge REF_CLK) disable iff (!RESET_N)
      state == ILMST_ARMED && line_evt |=> state == ILMST_HELD ##1 !MOTOR_STOP;
   endproperty
   a_relatch: assert property (p_relatch) else $error("No re-latch on line.");

   property p_pulse;
      @(posedge REF_CLK) disable iff (!RESET_N)
      state == ILMST_ARMED && coin_evt && !line_evt |=> MOTOR_STOP ##1 !MOTOR_STOP;
   endproperty
   a_pulse: assert property (p_pulse) else $error("Stop pulse wrong.");

   property p_delay;
      @(posedge REF_CLK) disable iff (!RESET_N)
      MOTOR_STOP |-> revs_since_line >= `ILMST_STOP_MIN && revs_since_line <= `ILMST_STOP_MAX;
   endproperty
   a_delay: assert property (p_delay) else $error("Stop delay out of range.");

   property p_frozen;
      @(posedge REF_CLK) disable iff (!RESET_N)
      disabled |=> cnt[0] == $past(cnt[0]) && cnt[1] == $past(cnt[1]);
   endproperty
   a_frozen: assert property (p_frozen) else $error("Counters moved when off.");

   property p_run_armed;
      @(posedge REF_CLK) disable iff (!RESET_N)
      state == ILMST_ARMED && step |=> cnt[1] != $past(cnt[1]);
   endproperty
   a_run_armed: assert property (p_run_armed) else $error("Armed count halted.");

   c_arm:     cover property (@(posedge REF_CLK) disable iff (!RESET_N) state == ILMST_ARMED);
   c_stop:    cover property (@(posedge REF_CLK) disable iff (!RESET_N) MOTOR_STOP);
   c_relatch: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
                              state == ILMST_ARMED && line_evt);
   c_disable: cover property (@(posedge REF_CLK) disable iff (!RESET_N) disabled && rev_evt);

endmodule

// [test/ilmst_motor_ctl_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Motor control partner
// ----------------------------------------------------------------------------
module ilmst_motor_ctl_model
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic stop_pulse,
   input  wire logic line_open,
   output logic      motor_on
);

   // A stop pulse wins over a line opening in the same cycle, because the
   // control tests the stop pulse before it restores a motor that is off.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         motor_on <= 1'h1;
      else if (stop_pulse)
         motor_on <= 1'h0;
      else if (line_open && !motor_on)
         motor_on <= 1'h1;
   end

endmodule

// [test/test_ilmst_timer.sv]
`timescale 1ns/1ps
`include "ilmst_defines.svh"

module test_ilmst_timer;

   localparam int PER = `ILMST_COIN_PERIOD;

   logic REF_CLK;
   logic RESET_N;
   logic SHAFT_REV;
   logic LINE_SIG;
   logic TIMER_DISABLE;
   logic MOTOR_STOP;
   logic STOP_ARMED;
   logic line_break;
   logic motor_on;
   logic stop_prev = 1'h0;
   int   mismatches;
   int   samples_checked;
   int   pulses = 0;
   int   stop_cycles = 0;

   // -------------------------------------------------------------------------
   // Design and partner
   // -------------------------------------------------------------------------
   ilmst_timer u_dut
   (
      .REF_CLK       (REF_CLK),
      .RESET_N       (RESET_N),
      .SHAFT_REV     (SHAFT_REV),
      .LINE_SIG      (LINE_SIG),
      .TIMER_DISABLE (TIMER_DISABLE),
      .MOTOR_STOP    (MOTOR_STOP),
      .STOP_ARMED    (STOP_ARMED)
   );

   ilmst_motor_ctl_model u_motor
   (
      .clk        (REF_CLK),
      .reset_n    (RESET_N),
      .stop_pulse (MOTOR_STOP),
      .line_open  (line_break),
      .motor_on   (motor_on)
   );

   initial
   begin
      REF_CLK = 1'h0;
      forever #4 REF_CLK = ~REF_CLK;
   end

   // Counting pulses and high cycles apart shows a stretched pulse.
   always @(posedge REF_CLK)
   begin
      stop_prev <= MOTOR_STOP;
      if (MOTOR_STOP === 1'h1)
         stop_cycles++;
      if (MOTOR_STOP === 1'h1 && stop_prev !== 1'h1)
         pulses++;
   end

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   task automatic check_bit(input logic act, input logic exp, input string what);
      samples_checked++;
      if (act !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask

   task automatic check_num(input int act, input int exp, input string what);
      samples_checked++;
      if (act != exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask

   // Pins need two cycles high and two low to pass the synchronisers.
   task automatic revs(input int n);
      repeat (n)
      begin
         @(posedge REF_CLK) SHAFT_REV <= 1'h1;
         repeat (2) @(posedge REF_CLK);
         SHAFT_REV <= 1'h0;
         @(posedge REF_CLK);
      end
      repeat (4) @(posedge REF_CLK);
      #1;
   endtask

   task automatic line_pulse;
      @(posedge REF_CLK) LINE_SIG <= 1'h1;
      repeat (2) @(posedge REF_CLK);
      LINE_SIG <= 1'h0;
      repeat (6) @(posedge REF_CLK);
      #1;
   endtask

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic run_arm;
      check_bit(STOP_ARMED, 1'h0, "armed after reset");
      revs(PER - 1);
      check_bit(STOP_ARMED, 1'h0, "armed early");
      revs(1);
      check_bit(STOP_ARMED, 1'h1, "not armed");
      check_num(pulses, 0, "early stop");
   endtask

   task automatic run_stop;
      revs(PER - 1);
      check_bit(STOP_ARMED, 1'h1, "arm lost");
      check_num(pulses, 0, "stop too soon");
      revs(1);
      check_num(pulses, 1, "no stop pulse");
      check_num(stop_cycles, 1, "pulse width");
      check_bit(STOP_ARMED, 1'h0, "armed after stop");
      check_bit(motor_on, 1'h0, "motor still on");
   endtask

   task automatic run_relatch;
      revs(PER);
      check_num(pulses, 1, "stop while stopped");
      check_bit(STOP_ARMED, 1'h0, "armed while stopped");
      @(posedge REF_CLK) line_break <= 1'h1;
      @(posedge REF_CLK) line_break <= 1'h0;
      @(posedge REF_CLK);
      #1;
      check_bit(motor_on, 1'h1, "motor not restored");
      line_pulse();
      revs(PER);
      check_bit(STOP_ARMED, 1'h1, "no rearm");
      line_pulse();
      check_bit(STOP_ARMED, 1'h0, "no relatch");
      revs(PER);
      check_bit(STOP_ARMED, 1'h1, "second arm");
      check_num(pulses, 1, "stop after relatch");
      revs(PER - 1);
      check_num(pulses, 1, "stop too early");
      revs(1);
      check_num(pulses, 2, "late stop");
   endtask

   task automatic run_disable;
      line_pulse();
      @(posedge REF_CLK) TIMER_DISABLE <= 1'h1;
      repeat (4) @(posedge REF_CLK);
      revs(PER * 2 + 88);
      check_bit(STOP_ARMED, 1'h0, "armed while off");
      check_num(pulses, 2, "stop while off");
      @(posedge REF_CLK) TIMER_DISABLE <= 1'h0;
      repeat (4) @(posedge REF_CLK);
      revs(PER - 1);
      check_bit(STOP_ARMED, 1'h0, "counters moved");
      revs(1);
      check_bit(STOP_ARMED, 1'h1, "frozen count");
   endtask

   task automatic conclude;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      RESET_N = 1'h0;
      SHAFT_REV = 1'h0;
      LINE_SIG = 1'h0;
      TIMER_DISABLE = 1'h0;
      line_break = 1'h0;
      mismatches = 0;
      samples_checked = 0;
      repeat (5) @(posedge REF_CLK);
      RESET_N <= 1'h1;
      repeat (2) @(posedge REF_CLK);
      #1;
      run_arm();
      run_stop();
      run_relatch();
      run_disable();
      conclude();
   end

endmodule
